// file: core_model.sv
// core model: runs the program counter, follows vectors, keeps the last pushed return address and counts pushes
`timescale 1ns/1ps
module core_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        push,
  input  wire logic [12:0] push_data,
  input  wire logic        load,
  input  wire logic [12:0] load_value,
  output logic      [12:0] pc,
  output logic      [12:0] stack_top,
  output int               takes
);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc <= 13'h0000;
      stack_top <= 13'h0000;
      takes <= 0;
    end else begin
      pc <= load ? load_value : pc + 13'h0001;
      if (push) begin
        stack_top <= push_data;
        takes <= takes + 1;
      end
    end
  end
endmodule : core_model

// file: icu_pkg.sv
// constants, register map and field positions for the interrupt control unit
// Contract
// [R1] every flag is set by its event regardless of any enable
// [R2] global enable at control bit 7 allows unmasked interrupts, blocks all when clear
// [R3] global enable plus any flag with its enable set takes the interrupt after the [R8] latency
// [R4] every reset clears the global enable
// [R5] return from handler leaves the routine and sets global enable again
// [R6] taking an interrupt clears global enable, pushes return address, vectors to 0004h
// [R7] software clears serviced flags before re-enabling, else it re-enters immediately
// [R8] pin and port-change latency is three or four instruction cycles by phase
// [R9] peripheral flags and enables in own registers, gated by the group enable
// [R10] pin edge: rising when edge select set, falling when clear; sets flag bit 1
// [R11] clearing the pin enable blocks its interrupt, flag still sets on edges
// [R12] pin interrupt wakes from sleep if enabled; global enable decides vectoring
// [R13] after wake the core continues at PC+1, or vectors to 0004h if enabled
// [R14] timer overflow FFh to 00h sets flag bit 2, gated by enable bit 5
// [R15] any change on port-B pins 7..4 sets flag bit 0, gated by its enable
// [R16] a wake leaves the waking flag set, other bits unchanged
// [R17] up to eight sources, each with its own flag bit
// [R18] pin and port inputs are synchronised before detection
// [R19] port change compares inputs to value latched at last port read
// [R20] peripheral flags and enables clear on reset, hold across wake
package icu_pkg;
  localparam int          CLK_HZ          = 25_000_000;
  localparam logic [3:0]  ADR_CONTROL     = 4'h0;
  localparam logic [3:0]  ADR_PERIPH_FLAG = 4'h4;
  localparam logic [3:0]  ADR_PERIPH_EN   = 4'h8;
  localparam logic [3:0]  ADR_OPTION      = 4'hC;
  localparam int          B_GIE           = 7;
  localparam int          B_PERIPHERAL_GROUP_ENABLE          = 6;
  localparam int          B_TMR_EN        = 5;
  localparam int          B_PIN_EN        = 4;
  localparam int          B_PORT_EN       = 3;
  localparam int          B_TMR_FLAG      = 2;
  localparam int          B_PIN_FLAG      = 1;
  localparam int          B_PORT_FLAG     = 0;
  localparam int          B_EDGE_SEL      = 6;
  localparam logic [7:0]  CONTROL_RST     = 8'h00;
  localparam logic [7:0]  PERIPH_RST      = 8'h00;
  localparam logic [7:0]  OPTION_RST      = 8'hFF;
  localparam logic [12:0] VECTOR_ADDR     = 13'h0004;
  localparam logic [7:0]  TIMER_MAX       = 8'hFF;
  localparam logic [1:0]  QPHASE_LAST     = 2'h3;
  localparam int          LAT_MIN_CYC     = 3;
  localparam int          LAT_MAX_CYC     = 4;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAIT, ST_VECTOR} icu_state_t;
endpackage : icu_pkg

// file: icu_properties.sv
// port timing checker for the interrupt control unit
`timescale 1ns/1ps
module icu_properties
  import icu_pkg::*;
(
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  input wire logic [12:0] CORE_PC,
  input wire logic        IRQ_TAKE,
  input wire logic        STACK_PUSH,
  input wire logic [12:0] STACK_DATA,
  input wire logic        PC_LOAD,
  input wire logic [12:0] PC_LOAD_VALUE,
  input wire logic        CORE_WAKE,
  input wire logic        CORE_SLEEPING
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);
  AST_TAKE_TRIO: assert property (IRQ_TAKE |-> STACK_PUSH && PC_LOAD)
    else $error("take without push and load");
  AST_VECTOR: assert property (PC_LOAD |-> PC_LOAD_VALUE == VECTOR_ADDR)
    else $error("wrong vector");
  AST_RETADDR: assert property (STACK_PUSH |-> STACK_DATA == $past(CORE_PC))
    else $error("wrong return address");
  // global enable is cleared on entry, so no second take can follow closely
  AST_TAKE_GAP: assert property (IRQ_TAKE |=> !IRQ_TAKE [*8])
    else $error("takes too close");
  AST_ACK_NEXT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  AST_ACK_ONCE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack stuck");
  AST_WAKE_SLEPT: assert property (CORE_WAKE |-> $past(CORE_SLEEPING))
    else $error("wake while running");
  AST_NO_TAKE_ASLEEP: assert property (CORE_SLEEPING |-> !IRQ_TAKE)
    else $error("vector while asleep");
endmodule : icu_properties

bind interrupt_control_unit icu_properties u_props (.CLK(CLK), .ARST_N(ARST_N),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .CORE_PC(CORE_PC),
  .IRQ_TAKE(IRQ_TAKE), .STACK_PUSH(STACK_PUSH), .STACK_DATA(STACK_DATA),
  .PC_LOAD(PC_LOAD), .PC_LOAD_VALUE(PC_LOAD_VALUE), .CORE_WAKE(CORE_WAKE),
  .CORE_SLEEPING(CORE_SLEEPING));

// file: interrupt_control_unit.sv
// interrupt control unit: flags, enables, vectoring, sleep wake, wishbone registers
`timescale 1ns/1ps
module interrupt_control_unit
  import icu_pkg::*;
#(
  parameter int NPERIPH = 6
) (
  input  wire logic               CLK,
  input  wire logic               ARST_N,
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  input  wire logic               WB_WE_I,
  input  wire logic [3:0]         WB_ADR_I,
  input  wire logic [31:0]        WB_DAT_I,
  input  wire logic [3:0]         WB_SEL_I,
  output logic      [31:0]        WB_DAT_O,
  output logic                    WB_ACK_O,
  input  wire logic               EXTERNAL_EVENT_PIN,
  input  wire logic [3:0]         PORT_B_PINS,
  input  wire logic               PORT_B_READ,
  input  wire logic [7:0]         EIGHT_BIT_TIMER,
  input  wire logic [NPERIPH-1:0] PERIPH_REQ,
  input  wire logic               SLEEP_EXEC,
  input  wire logic               RETURN_FROM_HANDLER,
  input  wire logic [12:0]        CORE_PC,
  output logic                    IRQ_TAKE,
  output logic                    STACK_PUSH,
  output logic      [12:0]        STACK_DATA,
  output logic                    PC_LOAD,
  output logic      [12:0]        PC_LOAD_VALUE,
  output logic                    CORE_WAKE,
  output logic                    CORE_SLEEPING
);
  logic               gie_r;
  logic               group_en_r;
  logic               tmr_en_r;
  logic               pin_en_r;
  logic               port_en_r;
  logic               tmr_flag_r;
  logic               pin_flag_r;
  logic               port_flag_r;
  logic [7:0]         control_byte;
  logic [7:0]         ctrl_wdata;
  logic [7:0]         pflag_wdata;
  logic [7:0]         pen_wdata;
  logic [7:0]         option_wdata;
  logic [NPERIPH-1:0] pflag_r;
  logic [NPERIPH-1:0] pen_r;
  logic [7:0]         option_r;
  logic [4:0]         sync_q;
  logic               pin_prev_r;
  logic [3:0]         port_latch_r;
  logic [7:0]         timer_prev_r;
  logic [1:0]         qphase_r;
  logic [1:0]         lat_cnt_r;
  icu_state_t         state_r;
  logic               ack_r;
  logic [31:0]        dat_r;

  logic wb_req;
  logic wb_wr;
  logic pin_edge;
  logic port_change;
  logic timer_ovf;
  logic pending;
  logic take_now;
  logic wake_ev;
  logic wr_control;
  logic wr_pflag;
  logic wr_pen;
  logic wr_option;
  logic vec_cycle;

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
    merge_byte = sel[0] ? d[7:0] : old;
  endfunction : merge_byte

  // every register write strobe shares this decode
  function automatic logic wr_hit(input logic wr, input logic [3:0] adr,
                                  input logic [3:0] target);
    wr_hit = wr && (adr == target);
  endfunction : wr_hit

  function automatic logic [7:0] widen(input logic [NPERIPH-1:0] v);
    widen = {{(8-NPERIPH){1'b0}}, v};
  endfunction : widen

  // [R18] pins pass through two flops before detection
  sync2 #(.W(5)) u_sync (
    .clk    (CLK),
    .arst_n (ARST_N),
    .d      ({PORT_B_PINS, EXTERNAL_EVENT_PIN}),
    .q      (sync_q)
  );

  assign wb_req = WB_CYC_I && WB_STB_I && !ack_r;
  assign wb_wr  = wb_req && WB_WE_I;

  assign wr_control   = wr_hit(wb_wr, WB_ADR_I, ADR_CONTROL);
  assign wr_pflag     = wr_hit(wb_wr, WB_ADR_I, ADR_PERIPH_FLAG);
  assign wr_pen       = wr_hit(wb_wr, WB_ADR_I, ADR_PERIPH_EN);
  assign wr_option    = wr_hit(wb_wr, WB_ADR_I, ADR_OPTION);
  // byte lane merges; a write with lane 0 off leaves the register as it is
  assign ctrl_wdata   = merge_byte(control_byte, WB_DAT_I, WB_SEL_I);
  assign pflag_wdata  = merge_byte(widen(pflag_r), WB_DAT_I, WB_SEL_I);
  assign pen_wdata    = merge_byte(widen(pen_r), WB_DAT_I, WB_SEL_I);
  assign option_wdata = merge_byte(option_r, WB_DAT_I, WB_SEL_I);
  assign vec_cycle    = state_r == ST_VECTOR;

  // edge select picks rising or falling edge [R10]
  assign pin_edge    = option_r[B_EDGE_SEL] ? (sync_q[0] && !pin_prev_r)
                                            : (!sync_q[0] && pin_prev_r);
  assign port_change = sync_q[4:1] != port_latch_r; // [R19] [R15]
  assign timer_ovf   = (timer_prev_r == TIMER_MAX) && (EIGHT_BIT_TIMER == 8'h00); // [R14]

  // each source gated by its own enable; peripherals by the group enable too [R9] [R11]
  assign pending = (pin_flag_r  && pin_en_r)
                || (tmr_flag_r  && tmr_en_r)
                || (port_flag_r && port_en_r)
                || (group_en_r && |(pflag_r & pen_r)); // [R17]
  // wake ignores the global enable [R12]
  assign wake_ev  = pending;
  assign take_now = gie_r && pending; // [R2] [R3]

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_prev_r   <= 1'b0;
      timer_prev_r <= 8'h00;
    end else begin
      pin_prev_r   <= sync_q[0];
      timer_prev_r <= EIGHT_BIT_TIMER;
    end
  end

  // port value latched on each core read of port B
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      port_latch_r <= 4'h0;
    end else if (PORT_B_READ) begin
      port_latch_r <= sync_q[4:1]; // [R19]
    end
  end

  // instruction cycle phase, four clocks per instruction cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      qphase_r <= 2'h0;
    end else begin
      qphase_r <= qphase_r + 2'h1;
    end
  end

  // global enable: entry clear beats a return or a write in the same cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gie_r <= CONTROL_RST[B_GIE]; // [R4]
    end else if (vec_cycle) begin
      gie_r <= 1'b0; // [R6]
    end else if (RETURN_FROM_HANDLER) begin
      gie_r <= 1'b1; // [R5]
    end else if (wr_control) begin
      gie_r <= ctrl_wdata[B_GIE]; // [R2]
    end
  end

  // software-owned enable bits of the control byte [R9] [R11] [R14] [R15]
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      group_en_r <= CONTROL_RST[B_PERIPHERAL_GROUP_ENABLE];
      tmr_en_r   <= CONTROL_RST[B_TMR_EN];
      pin_en_r   <= CONTROL_RST[B_PIN_EN];
      port_en_r  <= CONTROL_RST[B_PORT_EN];
    end else if (wr_control) begin
      group_en_r <= ctrl_wdata[B_PERIPHERAL_GROUP_ENABLE];
      tmr_en_r   <= ctrl_wdata[B_TMR_EN];
      pin_en_r   <= ctrl_wdata[B_PIN_EN];
      port_en_r  <= ctrl_wdata[B_PORT_EN];
    end
  end

  // hardware set beats a software clear, so no event is lost [R1] [R16]
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_flag_r <= CONTROL_RST[B_PIN_FLAG];
    end else if (pin_edge) begin
      pin_flag_r <= 1'b1; // [R10] [R1]
    end else if (wr_control) begin
      pin_flag_r <= ctrl_wdata[B_PIN_FLAG];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tmr_flag_r <= CONTROL_RST[B_TMR_FLAG];
    end else if (timer_ovf) begin
      tmr_flag_r <= 1'b1; // [R14] [R1]
    end else if (wr_control) begin
      tmr_flag_r <= ctrl_wdata[B_TMR_FLAG];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      port_flag_r <= CONTROL_RST[B_PORT_FLAG];
    end else if (port_change) begin
      port_flag_r <= 1'b1; // [R15] [R1]
    end else if (wr_control) begin
      port_flag_r <= ctrl_wdata[B_PORT_FLAG];
    end
  end

  // control byte rebuilt from its owners for reads and byte merges
  always_comb begin
    control_byte              = '0;
    control_byte[B_GIE]       = gie_r;
    control_byte[B_PERIPHERAL_GROUP_ENABLE]      = group_en_r;
    control_byte[B_TMR_EN]    = tmr_en_r;
    control_byte[B_PIN_EN]    = pin_en_r;
    control_byte[B_PORT_EN]   = port_en_r;
    control_byte[B_TMR_FLAG]  = tmr_flag_r;
    control_byte[B_PIN_FLAG]  = pin_flag_r;
    control_byte[B_PORT_FLAG] = port_flag_r;
  end

  // peripheral flags set by requests regardless of enables [R9] [R20]
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pflag_r <= PERIPH_RST[NPERIPH-1:0];
    end else if (wr_pflag) begin
      pflag_r <= pflag_wdata[NPERIPH-1:0] | PERIPH_REQ; // [R1]
    end else begin
      pflag_r <= pflag_r | PERIPH_REQ; // [R1]
    end
  end

  // peripheral enables are software owned
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pen_r <= PERIPH_RST[NPERIPH-1:0]; // [R20]
    end else if (wr_pen) begin
      pen_r <= pen_wdata[NPERIPH-1:0];
    end
  end

  // option byte holds the pin edge select [R10]
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      option_r <= OPTION_RST;
    end else if (wr_option) begin
      option_r <= option_wdata;
    end
  end

  // sequencer: run, sleep, latency wait, vector
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r   <= ST_RUN;
      lat_cnt_r <= 2'h0;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (take_now) begin
            // three cycles if the event lands at phase end, else four [R8]
            lat_cnt_r <= (qphase_r == QPHASE_LAST) ? 2'(LAT_MIN_CYC - 1)
                                                   : 2'(LAT_MAX_CYC - 1);
            state_r   <= ST_WAIT;
          end else if (SLEEP_EXEC) begin
            state_r <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake_ev) begin
            // with global enable clear the core just resumes at PC+1 [R13]
            state_r   <= gie_r ? ST_WAIT : ST_RUN;
            lat_cnt_r <= 2'(LAT_MAX_CYC - 1);
          end
        end
        ST_WAIT: begin
          // latency counted in instruction cycles, not instruction length [R8]
          if (qphase_r == QPHASE_LAST) begin
            if (lat_cnt_r == 2'h0) begin
              state_r <= ST_VECTOR;
            end else begin
              lat_cnt_r <= lat_cnt_r - 2'h1;
            end
          end
        end
        ST_VECTOR: begin
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  // vectoring outputs registered from the sequencer [R6] [R13]
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ_TAKE      <= 1'b0;
      STACK_PUSH    <= 1'b0;
      STACK_DATA    <= 13'h0000;
      PC_LOAD       <= 1'b0;
      PC_LOAD_VALUE <= 13'h0000;
      CORE_WAKE     <= 1'b0;
    end else begin
      IRQ_TAKE   <= state_r == ST_VECTOR;
      STACK_PUSH <= state_r == ST_VECTOR;
      PC_LOAD    <= state_r == ST_VECTOR;
      CORE_WAKE  <= (state_r == ST_SLEEP) && wake_ev; // [R12]
      if (state_r == ST_VECTOR) begin
        STACK_DATA    <= CORE_PC; // [R6]
        PC_LOAD_VALUE <= VECTOR_ADDR; // [R6]
      end
    end
  end

  assign CORE_SLEEPING = state_r == ST_SLEEP;

  // wishbone slave: one wait state, unmapped reads return zero
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      if (wb_req && !WB_WE_I) begin
        case (WB_ADR_I)
          ADR_CONTROL:     dat_r <= {24'h000000, control_byte};
          ADR_PERIPH_FLAG: dat_r <= {{(32-NPERIPH){1'b0}}, pflag_r};
          ADR_PERIPH_EN:   dat_r <= {{(32-NPERIPH){1'b0}}, pen_r};
          ADR_OPTION:      dat_r <= {24'h000000, option_r};
          default:         dat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_r;
endmodule : interrupt_control_unit

// file: sync2.sv
// two-flop synchroniser bank for asynchronous pins
`timescale 1ns/1ps
module sync2
  import icu_pkg::*;
#(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage read only by the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sync2

// file: test_interrupt_control_unit.sv
// self-checking bench for the interrupt control unit
`timescale 1ns/1ps
module test_interrupt_control_unit;
  import icu_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        pin = 1'b0, prd = 1'b0, slp = 1'b0, rfh = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0, pins = 4'h0;
  logic [31:0] dat = 32'h0, dat_o, rdat;
  logic [7:0]  tmr = 8'h00;
  logic [5:0]  req = 6'h00;
  logic        ack, take, push, load, wake, sleeping;
  logic [12:0] pc, sdata, lval, top, ret;
  int          takes, n, n_fail = 0, checks = 0;
  always #20 clk = ~clk;
  interrupt_control_unit dut (.CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(sel), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .EXTERNAL_EVENT_PIN(pin), .PORT_B_PINS(pins), .PORT_B_READ(prd),
    .EIGHT_BIT_TIMER(tmr), .PERIPH_REQ(req), .SLEEP_EXEC(slp), .RETURN_FROM_HANDLER(rfh),
    .CORE_PC(pc), .IRQ_TAKE(take), .STACK_PUSH(push), .STACK_DATA(sdata), .PC_LOAD(load),
    .PC_LOAD_VALUE(lval), .CORE_WAKE(wake), .CORE_SLEEPING(sleeping));
  core_model core (.clk(clk), .arst_n(arst_n), .push(push), .push_data(sdata),
    .load(load), .load_value(lval), .pc(pc), .stack_top(top), .takes(takes));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bail(input string nm);
    n_fail++;
    $display("[FAIL] %s expected event seen timeout", nm);
    tally_and_finish;
  endtask : bail
  // request held until ack is sampled high, then released for at least one cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int i;
    i = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, 4'h1, 24'h000000, d};
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    rdat = dat_o;
    {cyc, stb, we} <= 3'h0;
    if (i >= 20) bail("bus ack");
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    wb(1'b0, a, 8'h00);
    chk(nm, {24'h000000, e}, rdat);
  endtask : rd
  task automatic await(input logic for_wake, output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while ((for_wake ? wake : take) !== 1'b1 && k < 40);
    if (k >= 40) bail(for_wake ? "wake" : "take");
  endtask : await
  task automatic t_reset;
    wb(1'b1, 4'h2, 8'hFF);
    rd(ADR_CONTROL, 8'h00, "control");
    rd(ADR_PERIPH_FLAG, 8'h00, "periph flags");
    rd(ADR_PERIPH_EN, 8'h00, "periph enables");
    rd(ADR_OPTION, 8'hFF, "option");
    rd(4'h2, 8'h00, "unmapped");
    $display("reset test done");
  endtask : t_reset
  task automatic t_flags;
    @(posedge clk);
    {pin, tmr, prd} <= {1'b1, 8'hFF, 1'b1};
    @(posedge clk);
    {tmr, prd, req} <= {8'h00, 1'b0, 6'h04};
    @(posedge clk);
    {pins, req} <= {4'hA, 6'h00};
    repeat (6) @(posedge clk);
    rd(ADR_CONTROL, 8'h07, "source flags");
    rd(ADR_PERIPH_FLAG, 8'h04, "periph flag");
    chk("takes", 32'h0, takes);
    prd <= 1'b1;
    @(posedge clk);
    prd <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b1, ADR_PERIPH_FLAG, 8'h00);
    wb(1'b1, ADR_CONTROL, 8'h00);
    rd(ADR_CONTROL, 8'h00, "port relatched");
    $display("flag test done");
  endtask : t_flags
  task automatic t_take;
    wb(1'b1, ADR_OPTION, 8'hBF);
    wb(1'b1, ADR_CONTROL, 8'h90);
    @(posedge clk);
    pin <= 1'b0;
    await(1'b0, n);
    chk("latency", 32'h1, 32'(n >= 12 && n <= 24));
    chk("vector", 32'(VECTOR_ADDR), 32'(lval));
    rd(ADR_CONTROL, 8'h12, "entry clears global");
    rfh <= 1'b1;
    @(posedge clk);
    rfh <= 1'b0;
    await(1'b0, n);
    ret = pc - 13'h0001;
    @(posedge clk);
    chk("takes", 32'h2, takes);
    chk("pc at vector", 32'(VECTOR_ADDR), 32'(pc));
    chk("return address", 32'(ret), 32'(top));
    wb(1'b1, ADR_CONTROL, 8'h00);
    $display("take test done");
  endtask : t_take
  task automatic t_periph;
    wb(1'b1, ADR_PERIPH_EN, 8'h01);
    wb(1'b1, ADR_CONTROL, 8'h80);
    req <= 6'h01;
    @(posedge clk);
    req <= 6'h00;
    repeat (40) @(posedge clk);
    chk("group gate", 32'h2, takes);
    rd(ADR_PERIPH_FLAG, 8'h01, "periph flag");
    wb(1'b1, ADR_CONTROL, 8'hC0);
    await(1'b0, n);
    wb(1'b1, ADR_PERIPH_FLAG, 8'h00);
    wb(1'b1, ADR_CONTROL, 8'h10);
    $display("peripheral test done");
  endtask : t_periph
  task automatic t_sleep;
    {pin, slp} <= 2'h3;
    @(posedge clk);
    slp <= 1'b0;
    repeat (4) @(posedge clk);
    chk("sleeping", 32'h1, 32'(sleeping));
    pin <= 1'b0;
    await(1'b1, n);
    repeat (30) @(posedge clk);
    chk("no vector", 32'h3, takes);
    rd(ADR_CONTROL, 8'h12, "wake cause");
    wb(1'b1, ADR_CONTROL, 8'h90);
    {pin, slp} <= 2'h3;
    @(posedge clk);
    slp <= 1'b0;
    repeat (4) @(posedge clk);
    chk("asleep again", 32'h1, 32'(sleeping));
    pin <= 1'b0;
    await(1'b1, n);
    await(1'b0, n);
    @(posedge clk);
    chk("vector after wake", 32'h4, takes);
    $display("sleep test done");
  endtask : t_sleep
  // reset in mid-run with the global enable set
  task automatic t_rereset;
    wb(1'b1, ADR_CONTROL, 8'h80);
    pins <= 4'h0;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(ADR_CONTROL, 8'h00, "control after reset");
    rd(ADR_PERIPH_EN, 8'h00, "enables after reset");
    rd(ADR_OPTION, 8'hFF, "option after reset");
    $display("mid-run reset test done");
  endtask : t_rereset
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_reset;
    t_flags;
    t_take;
    t_periph;
    t_sleep;
    t_rereset;
    tally_and_finish;
  end
endmodule : test_interrupt_control_unit
